//--- src/hsb_defines.svh
// Purpose: Constants of the fast pad block lane (offsets, fields, resets, counts)
// Assumes: APB byte addresses, 32-bit data, one word per register
// Notes:   Types live in hsb_pkg
`ifndef HSB_DEFINES_SVH
`define HSB_DEFINES_SVH

`define HSB_CTRL_OFS   8'h00
`define HSB_STAT_OFS   8'h04
`define HSB_RXD_OFS    8'h08
`define HSB_LANE_OFS   8'h0c

`define HSB_CTRL_BITS  13
`define HSB_CTRL_RST   13'h0008
`define HSB_MAX_W      4'ha
`define HSB_HS_W       4'h8
`define HSB_MIPI_DIV   4'h8
`define HSB_FIFO_DEPTH 8
`define HSB_LOCK_WORDS 16
`define HSB_DLY_W      6

`define HSB_SYNC_N     6
`define HSB_S_PADP     0
`define HSB_S_PADN     1
`define HSB_S_RXBIT    2
`define HSB_S_RXWORD   3
`define HSB_S_TXBIT    4
`define HSB_S_TXWORD   5

`endif

//--- src/hsb_pkg.sv
// Purpose: Types of the fast pad block lane
// Assumes: Constants come from hsb_defines.svh
// Notes:   Control word layout is the CTRL register layout, LSB first from width
package hsb_pkg;

    typedef struct packed {
        logic [1:0] lane_code;
        logic       term_static;
        logic       term_dyn;
        logic       mipi_on;
        logic       hs_sel;
        logic       dpa_on;
        logic       fifo_on;
        logic       half_rate;
        logic [3:0] width;
    } hsb_ctrl_t;

    typedef struct packed {
        logic p;
        logic n;
    } hsb_pad_t;

    typedef enum {
        HSB_TRAIN,
        HSB_LOCKED
    } hsb_dpa_state_t;

endpackage : hsb_pkg

//--- src/hsb_fifo.sv
// Purpose: Receive word FIFO
// Assumes: DEPTH is a power of two
// Notes:   Push when full is dropped, pop when empty is ignored
`timescale 1ns/1ps
`default_nettype none
`include "hsb_defines.svh"

module hsb_fifo
    import hsb_pkg::*;
#(
    parameter int W     = 10,
    parameter int DEPTH = `HSB_FIFO_DEPTH,
    parameter int AW    = $clog2(DEPTH)
) (
    // Clock and reset
    input  wire logic          clk,
    input  wire logic          rst_n,
    input  wire logic          ce,
    // Write side
    input  wire logic          push,
    input  wire logic [W-1:0]  din,
    // Read side
    input  wire logic          pop,
    output logic      [W-1:0]  dout,
    output logic               empty,
    output logic               full,
    output logic      [AW:0]   level
);

    logic [W-1:0]  mem_ff [DEPTH];
    logic [AW-1:0] wr_ff;
    logic [AW-1:0] rd_ff;
    logic [AW:0]   cnt_ff;
    logic          do_push;
    logic          do_pop;

    assign do_push = push & ~full;
    assign do_pop  = pop & ~empty;

    always_ff @(posedge clk) begin
        if (ce && do_push) begin
            mem_ff[wr_ff] <= din;
        end
    end

    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            wr_ff  <= '0;
            rd_ff  <= '0;
            cnt_ff <= '0;
        end else if (ce) begin
            if (do_push) begin
                wr_ff <= wr_ff + 1'b1;
            end
            if (do_pop) begin
                rd_ff <= rd_ff + 1'b1;
            end
            cnt_ff <= cnt_ff + (AW+1)'(do_push) - (AW+1)'(do_pop);
        end
    end

    assign dout  = mem_ff[rd_ff];
    assign empty = (cnt_ff == '0);
    assign full  = (cnt_ff == (AW+1)'(DEPTH));
    assign level = cnt_ff;

endmodule : hsb_fifo
`default_nettype wire

//--- src/hsb_dly.sv
// Purpose: Delay counter and phase alignment trainer
// Assumes: tick is one cycle per received word
// Notes:   Training sweeps the delay until LOCK_WORDS words in a row each equal the word before
`timescale 1ns/1ps
`default_nettype none
`include "hsb_defines.svh"

module hsb_dly
    import hsb_pkg::*;
#(
    parameter int DW         = `HSB_DLY_W,
    parameter int LOCK_WORDS = `HSB_LOCK_WORDS,
    parameter int CW         = $clog2(LOCK_WORDS + 1)
) (
    // Clock and reset
    input  wire logic          clk,
    input  wire logic          rst_n,
    input  wire logic          ce,
    // Fabric controls
    input  wire logic          tick,
    input  wire logic          adj_on,
    input  wire logic          step_up,
    input  wire logic          clr,
    input  wire logic          dpa_on,
    input  wire logic [9:0]    word,
    // Results
    output logic      [DW-1:0] delay,
    output logic               lock
);

    hsb_dpa_state_t state_ff;
    logic [DW-1:0]  dly_ff;
    logic [9:0]     prev_ff;
    logic [CW-1:0]  stable_ff;
    logic           same;

    assign same = (word == prev_ff);

    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            prev_ff <= '0;
        end else if (ce && tick) begin
            prev_ff <= word;
        end
    end

    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            dly_ff <= '0;
        end else if (ce && tick) begin
            if (clr) begin
                dly_ff <= '0;
            end else if (adj_on && !dpa_on) begin
                if (step_up && dly_ff != '1) begin
                    dly_ff <= dly_ff + 1'b1;
                end else if (!step_up && dly_ff != '0) begin
                    dly_ff <= dly_ff - 1'b1;
                end
            end else if (adj_on && state_ff == HSB_TRAIN && !same) begin
                dly_ff <= dly_ff + 1'b1;
            end
        end
    end

    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            state_ff  <= HSB_TRAIN;
            stable_ff <= '0;
        end else if (ce && tick) begin
            if (clr || !dpa_on) begin
                state_ff  <= HSB_TRAIN;
                stable_ff <= '0;
            end else if (adj_on) begin
                case (state_ff)
                    HSB_TRAIN: begin
                        if (!same) begin
                            stable_ff <= '0;
                        end else if (stable_ff == CW'(LOCK_WORDS - 1)) begin
                            state_ff <= HSB_LOCKED;
                        end else begin
                            stable_ff <= stable_ff + 1'b1;
                        end
                    end
                    HSB_LOCKED: begin
                        state_ff <= HSB_LOCKED;
                    end
                    default: begin
                        state_ff <= HSB_TRAIN;
                    end
                endcase
            end
        end
    end

    assign delay = dly_ff;
    assign lock  = dpa_on & (state_ff == HSB_LOCKED);

endmodule : hsb_dly
`default_nettype wire

//--- src/hsb_top.sv
// Purpose: Bidirectional fast pad block lane with serializer, deserializer and APB control
// Assumes: Pads and lane clocks are asynchronous pins sampled on sys_clk
// Notes:   rx_side_reset and tx_side_reset are active high fabric levels
`timescale 1ns/1ps
`default_nettype none
`include "hsb_defines.svh"

module hsb_top
    import hsb_pkg::*;
#(
    parameter int GROUP_ID = 0,
    parameter int LANE_ID  = 0,
    parameter int DLY_W    = `HSB_DLY_W
) (
    // Clock, reset, enable
    input  wire logic        sys_clk,
    input  wire logic        resetn,
    input  wire logic        clk_en,
    // APB slave
    input  wire logic [7:0]  paddr,
    input  wire logic        psel,
    input  wire logic        penable,
    input  wire logic        pwrite,
    input  wire logic [31:0] pwdata,
    output logic      [31:0] prdata,
    output logic             pready,
    output logic             pslverr,
    // Lane clocks from pins
    input  wire logic        rx_bit_clock,
    input  wire logic        rx_word_clock,
    input  wire logic        tx_bit_clock,
    input  wire logic        tx_word_clock,
    // Pads
    input  wire hsb_pad_t    pad_in,
    output hsb_pad_t         pad_out,
    output logic             pad_oe_n,
    // Fabric receive side
    input  wire logic        rx_side_reset,
    input  wire logic        rx_buffer_on,
    input  wire logic        term_on,
    input  wire logic        core_read_pop,
    output logic      [9:0]  rx_word,
    output logic             rx_word_valid,
    output logic             fifo_empty,
    output logic             lock,
    output logic             buffer_active,
    output logic             term_active,
    // Fabric delay control
    input  wire logic        delay_adjust_on,
    input  wire logic        delay_step_up,
    input  wire logic        delay_counter_clear,
    // Fabric transmit side
    input  wire logic        tx_side_reset,
    input  wire logic        tx_oe,
    input  wire logic [9:0]  tx_word,
    // Low power lane data
    input  wire hsb_pad_t    lp_out,
    output hsb_pad_t         lp_in,
    // Clock lane forwarding
    output logic             fwd_bit_tick,
    output logic             fwd_word_tick
);

    ////////////////////////////////////////////////////////////////////////////
    // Width decode shared by both directions

    function automatic logic [3:0] eff_width(input hsb_ctrl_t c);
        logic [3:0] w;
        w = c.width;
        if (c.mipi_on) begin
            w = `HSB_HS_W;
        end else if (w == 4'h0 || w > `HSB_MAX_W) begin
            w = `HSB_MAX_W;
        end
        return w;
    endfunction : eff_width

    function automatic logic reg_hit(input logic [7:0] a, input logic [7:0] ofs);
        return a[7:2] == ofs[7:2];
    endfunction : reg_hit

    ////////////////////////////////////////////////////////////////////////////
    // Pin synchronisers and edge detect

    logic [`HSB_SYNC_N-1:0] pin_raw;
    logic [`HSB_SYNC_N-1:0] sync1_ff;
    logic [`HSB_SYNC_N-1:0] sync2_ff;
    logic [`HSB_SYNC_N-1:0] prev_ff;
    logic [`HSB_SYNC_N-1:0] rise;
    logic [`HSB_SYNC_N-1:0] fall;

    assign pin_raw = {tx_word_clock, tx_bit_clock, rx_word_clock, rx_bit_clock,
                      pad_in.n, pad_in.p};

    genvar gi;
    generate
        for (gi = 0; gi < `HSB_SYNC_N; gi++) begin : g_sync
            always_ff @(posedge sys_clk or negedge resetn) begin
                if (!resetn) begin
                    sync1_ff[gi] <= 1'b0;
                    sync2_ff[gi] <= 1'b0;
                    prev_ff[gi]  <= 1'b0;
                end else if (clk_en) begin
                    sync1_ff[gi] <= pin_raw[gi];
                    sync2_ff[gi] <= sync1_ff[gi];
                    prev_ff[gi]  <= sync2_ff[gi];
                end
            end
            assign rise[gi] = sync2_ff[gi] & ~prev_ff[gi];
            assign fall[gi] = ~sync2_ff[gi] & prev_ff[gi];
        end
    endgenerate

    ////////////////////////////////////////////////////////////////////////////
    // Control register and APB slave

    hsb_ctrl_t   ctrl_ff;
    logic [31:0] prdata_ff;
    logic [31:0] rd_mux;
    logic        mapped;
    logic        wr_ctrl;
    logic [3:0]  width;
    logic [3:0]  lane_cnt;
    logic [$clog2(`HSB_FIFO_DEPTH):0] fifo_level;
    logic [9:0]  cap_ff;
    logic [DLY_W-1:0] delay_val;

    assign width    = eff_width(ctrl_ff);
    assign lane_cnt = 4'h1 << ctrl_ff.lane_code;
    assign mapped   = reg_hit(paddr, `HSB_CTRL_OFS) | reg_hit(paddr, `HSB_STAT_OFS) |
                      reg_hit(paddr, `HSB_RXD_OFS) | reg_hit(paddr, `HSB_LANE_OFS);
    assign wr_ctrl  = psel & penable & pwrite & reg_hit(paddr, `HSB_CTRL_OFS);

    always_ff @(posedge sys_clk or negedge resetn) begin
        if (!resetn) begin
            ctrl_ff <= hsb_ctrl_t'(`HSB_CTRL_RST);
        end else if (clk_en && wr_ctrl) begin
            ctrl_ff <= hsb_ctrl_t'(pwdata[`HSB_CTRL_BITS-1:0]);
        end
    end

    always_comb begin
        rd_mux = 32'h0000_0000;
        if (reg_hit(paddr, `HSB_CTRL_OFS)) begin
            rd_mux[`HSB_CTRL_BITS-1:0] = ctrl_ff;
        end else if (reg_hit(paddr, `HSB_STAT_OFS)) begin
            rd_mux[0]              = lock;
            rd_mux[1]              = fifo_empty;
            rd_mux[2]              = buffer_active;
            rd_mux[3]              = term_active;
            rd_mux[4]              = ~pad_oe_n;
            rd_mux[11:8]           = width;
            rd_mux[16 +: $bits(fifo_level)] = fifo_level;
            rd_mux[24 +: DLY_W]    = delay_val;
        end else if (reg_hit(paddr, `HSB_RXD_OFS)) begin
            rd_mux[9:0] = cap_ff;
        end else if (reg_hit(paddr, `HSB_LANE_OFS)) begin
            rd_mux[3:0]  = lane_cnt;
            rd_mux[10:8] = 3'(LANE_ID);
            rd_mux[19:16] = 4'(GROUP_ID);
        end
    end

    always_ff @(posedge sys_clk or negedge resetn) begin
        if (!resetn) begin
            prdata_ff <= 32'h0000_0000;
        end else if (clk_en && psel && !penable && !pwrite) begin
            prdata_ff <= rd_mux;
        end
    end

    assign prdata  = prdata_ff;
    assign pready  = 1'b1;
    assign pslverr = psel & penable & ~mapped;

    ////////////////////////////////////////////////////////////////////////////
    // Receive strobes and clock lane divider

    logic rx_rst_n;
    logic tx_rst_n;
    logic rx_bit_tk;
    logic rx_word_tk;
    logic div_tk;
    logic hs_path;
    logic [3:0] div_ff;

    assign rx_rst_n  = resetn & ~rx_side_reset;
    assign tx_rst_n  = resetn & ~tx_side_reset;
    assign hs_path   = ~ctrl_ff.mipi_on | ctrl_ff.hs_sel;
    assign rx_bit_tk = rise[`HSB_S_RXBIT] | (ctrl_ff.half_rate & fall[`HSB_S_RXBIT]);
    assign div_tk    = rx_bit_tk && div_ff == `HSB_MIPI_DIV - 4'h1;
    assign rx_word_tk = ctrl_ff.mipi_on ? div_tk : rise[`HSB_S_RXWORD];

    always_ff @(posedge sys_clk or negedge rx_rst_n) begin
        if (!rx_rst_n) begin
            div_ff        <= 4'h0;
            fwd_bit_tick  <= 1'b0;
            fwd_word_tick <= 1'b0;
        end else if (clk_en) begin
            if (div_tk) begin
                div_ff <= 4'h0;
            end else if (rx_bit_tk) begin
                div_ff <= div_ff + 4'h1;
            end
            fwd_bit_tick  <= ctrl_ff.mipi_on & rx_bit_tk;
            fwd_word_tick <= ctrl_ff.mipi_on & div_tk;
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // Deserializer

    logic [9:0] rx_sh_ff;
    logic [9:0] nxt_rx_sh;
    logic       cap_tk_ff;

    // Word capture sees the bit shifted in the same cycle (MIPI divider tick)
    assign nxt_rx_sh = (rx_bit_tk && rx_buffer_on && hs_path) ?
                       {sync2_ff[`HSB_S_PADP], rx_sh_ff[9:1]} : rx_sh_ff;

    always_ff @(posedge sys_clk or negedge rx_rst_n) begin
        if (!rx_rst_n) begin
            rx_sh_ff  <= 10'h000;
            cap_ff    <= 10'h000;
            cap_tk_ff <= 1'b0;
        end else if (clk_en) begin
            cap_tk_ff <= 1'b0;
            rx_sh_ff <= nxt_rx_sh;
            if (rx_word_tk && hs_path) begin
                cap_ff    <= nxt_rx_sh >> (`HSB_MAX_W - width);
                cap_tk_ff <= 1'b1;
            end
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // Receive FIFO and word output

    logic [9:0] fifo_dout;
    logic       f_empty;
    logic       do_pop;

    assign do_pop = ctrl_ff.fifo_on & core_read_pop & ~f_empty;

    hsb_fifo #(
        .W     (10),
        .DEPTH (`HSB_FIFO_DEPTH)
    ) u_fifo (
        .clk   (sys_clk),
        .rst_n (rx_rst_n),
        .ce    (clk_en),
        .push  (ctrl_ff.fifo_on & cap_tk_ff),
        .din   (cap_ff),
        .pop   (do_pop),
        .dout  (fifo_dout),
        .empty (f_empty),
        .full  (),
        .level (fifo_level)
    );

    assign fifo_empty = ~ctrl_ff.fifo_on | f_empty;

    always_ff @(posedge sys_clk or negedge rx_rst_n) begin
        if (!rx_rst_n) begin
            rx_word       <= 10'h000;
            rx_word_valid <= 1'b0;
        end else if (clk_en) begin
            rx_word_valid <= 1'b0;
            if (do_pop) begin
                rx_word       <= fifo_dout;
                rx_word_valid <= 1'b1;
            end else if (!ctrl_ff.fifo_on && cap_tk_ff) begin
                rx_word       <= cap_ff;
                rx_word_valid <= 1'b1;
            end
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // Delay control and phase alignment

    hsb_dly #(
        .DW         (DLY_W),
        .LOCK_WORDS (`HSB_LOCK_WORDS)
    ) u_dly (
        .clk     (sys_clk),
        .rst_n   (rx_rst_n),
        .ce      (clk_en),
        .tick    (rx_word_tk),
        .adj_on  (delay_adjust_on),
        .step_up (delay_step_up),
        .clr     (delay_counter_clear),
        .dpa_on  (ctrl_ff.dpa_on),
        .word    (nxt_rx_sh >> (`HSB_MAX_W - width)),
        .delay   (delay_val),
        .lock    (lock)
    );

    ////////////////////////////////////////////////////////////////////////////
    // Serializer

    logic [9:0] tx_sh_ff;
    logic       tx_bit_ff;
    logic       tx_bit_tk;

    assign tx_bit_tk = rise[`HSB_S_TXBIT] | (ctrl_ff.half_rate & fall[`HSB_S_TXBIT]);

    always_ff @(posedge sys_clk or negedge tx_rst_n) begin
        if (!tx_rst_n) begin
            tx_sh_ff  <= 10'h000;
            tx_bit_ff <= 1'b0;
        end else if (clk_en) begin
            if (rise[`HSB_S_TXWORD]) begin
                tx_sh_ff <= tx_word & ~(10'h3ff << width);
            end else if (tx_bit_tk) begin
                tx_bit_ff <= tx_sh_ff[0];
                tx_sh_ff  <= {1'b0, tx_sh_ff[9:1]};
            end
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // Pad drive, buffer and termination

    always_ff @(posedge sys_clk or negedge tx_rst_n) begin
        if (!tx_rst_n) begin
            pad_out  <= '0;
            pad_oe_n <= 1'b1;
        end else if (clk_en) begin
            pad_oe_n <= ~tx_oe;
            if (hs_path) begin
                pad_out <= '{p: tx_bit_ff, n: ~tx_bit_ff};
            end else begin
                pad_out <= lp_out;
            end
        end
    end

    always_ff @(posedge sys_clk or negedge resetn) begin
        if (!resetn) begin
            buffer_active <= 1'b0;
            term_active   <= 1'b0;
            lp_in         <= '0;
        end else if (clk_en) begin
            buffer_active <= rx_buffer_on;
            term_active   <= ctrl_ff.term_dyn ? term_on : ctrl_ff.term_static;
            lp_in         <= '{p: sync2_ff[`HSB_S_PADP], n: sync2_ff[`HSB_S_PADN]};
        end
    end

endmodule : hsb_top
`default_nettype wire

//--- verification/hsb_top_properties.sv
// Purpose: Port assertions of hsb_top
// Assumes: Control bits shadowed from APB writes
// Notes:   Bind follows the module
`timescale 1ns/1ps
`default_nettype none
`include "hsb_defines.svh"
module hsb_props
    import hsb_pkg::*;
(
    input wire logic        sys_clk, resetn, clk_en, psel, penable, pwrite,
    input wire logic [7:0]  paddr,
    input wire logic [31:0] pwdata,
    input wire logic        rx_buffer_on, buffer_active, term_on, term_active,
    input wire logic        rx_side_reset, tx_side_reset, tx_oe, pad_oe_n,
    input wire logic        fifo_empty, lock, rx_word_valid,
    input wire hsb_pad_t    pad_out
);
    hsb_ctrl_t c_ff;
    always_ff @(posedge sys_clk or negedge resetn) begin
        if (!resetn)
            c_ff <= `HSB_CTRL_RST;
        else if (clk_en && psel && penable && pwrite && paddr == `HSB_CTRL_OFS)
            c_ff <= pwdata[12:0];
    end
    default clocking @(posedge sys_clk); endclocking
    default disable iff (!resetn);
    sequence v_pulse;
        rx_word_valid ##1 !rx_word_valid;
    endsequence
    a_valid_pulse: assert property (rx_word_valid |-> v_pulse)
        else $error("valid too long");
    a_buf_follow: assert property (clk_en |=> buffer_active == $past(rx_buffer_on))
        else $error("buffer state");
    a_term_follow: assert property (clk_en && c_ff.term_dyn |=> term_active == $past(term_on))
        else $error("term state");
    a_lock_dpa: assert property (!c_ff.dpa_on |-> !lock)
        else $error("lock without alignment");
    a_fifo_off: assert property (!c_ff.fifo_on |-> fifo_empty)
        else $error("empty flag low");
    a_rx_reset: assert property (rx_side_reset |-> fifo_empty && !lock && !rx_word_valid)
        else $error("rx reset");
    a_tx_reset: assert property (tx_side_reset |-> pad_oe_n && pad_out == '0)
        else $error("tx reset");
    a_oe_drive: assert property (clk_en |=> tx_side_reset || pad_oe_n == !$past(tx_oe))
        else $error("output enable");
endmodule : hsb_props
bind hsb_top hsb_props u_hsb_props (.sys_clk, .resetn, .clk_en, .psel, .penable, .pwrite,
    .paddr, .pwdata, .rx_buffer_on, .buffer_active, .term_on, .term_active, .rx_side_reset,
    .tx_side_reset, .tx_oe, .pad_oe_n, .fifo_empty, .lock, .rx_word_valid, .pad_out);
`default_nettype wire

//--- verification/hsb_remote.sv
// Purpose: Remote serial transmitter and receiver
// Assumes: Tasks entered at a rising edge of sys_clk
// Notes:   Clocks stand still outside frames
`timescale 1ns/1ps
`default_nettype none
module hsb_remote
    import hsb_pkg::*;
(
    input  wire logic     sys_clk,
    input  wire hsb_pad_t pad_out,
    output logic          rx_bit_clock = '0,
    output logic          rx_word_clock = '0,
    output logic          tx_bit_clock = '0,
    output logic          tx_word_clock = '0,
    output hsb_pad_t      rem_pad = '0
);
    task automatic hold(input int n);
        repeat (n) @(posedge sys_clk);
    endtask : hold
    task automatic send(input logic [9:0] w, input int n);
        for (int i = 0; i < n; i++) begin
            rem_pad <= '{p: w[i], n: !w[i]};
            rx_bit_clock <= '0;
            hold(3);
            rx_bit_clock <= '1;
            hold(3);
        end
        rx_bit_clock <= '0;
        rx_word_clock <= '1;
        rem_pad <= '{p: !rem_pad.p, n: rem_pad.p};
        hold(3);
        rx_word_clock <= '0;
        hold(3);
    endtask : send
    task automatic recv(output logic [9:0] w, input int n);
        w = '0;
        tx_word_clock <= '1;
        hold(3);
        tx_word_clock <= '0;
        for (int i = 0; i < n; i++) begin
            hold(3);
            tx_bit_clock <= '1;
            hold(6);
            w[i] = pad_out.p;
            tx_bit_clock <= '0;
        end
    endtask : recv
endmodule : hsb_remote
`default_nettype wire

//--- verification/hsb_top_bench.sv
// Purpose: Self-checking bench of hsb_top
// Assumes: Remote model drives the lane pins
// Notes:   Read and receive results queued by drivers, compared by monitor; transmit, lock and pad_oe_n checked inline
`timescale 1ns/1ps
`default_nettype none
module hsb_top_bench
    import hsb_pkg::*;
;
    logic        sys_clk = 0, resetn = 0, psel = 0, penable = 0, pwrite = 0;
    logic        rx_side_reset = 0, rx_buffer_on = 0, term_on = 0, core_read_pop = 0, clk_en = 1;
    logic        delay_adjust_on = 0, delay_step_up = 0, delay_counter_clear = 0;
    logic        tx_side_reset = 0, tx_oe = 0, pad_oe_n, rx_word_valid, fifo_empty, lock;
    logic        pready, rx_bit_clock, rx_word_clock, tx_bit_clock, tx_word_clock;
    logic [7:0]  paddr = '0;
    logic [9:0]  tx_word = '0, rx_word, got;
    logic [31:0] pwdata = '0, prdata, rx_q[$], rd_e[$], rd_m[$];
    hsb_pad_t    pad_in, pad_out, rem_pad;
    int          n_fail = 0, n_checks = 0;
    assign pad_in = pad_oe_n ? rem_pad : pad_out;
    always #12.5 sys_clk = ~sys_clk;
    hsb_top u_hsb_top (.sys_clk, .resetn, .clk_en, .paddr, .psel, .penable, .pwrite,
        .pwdata, .prdata, .pready, .pslverr(), .rx_bit_clock, .rx_word_clock, .tx_bit_clock,
        .tx_word_clock, .pad_in, .pad_out, .pad_oe_n, .rx_side_reset, .rx_buffer_on, .term_on,
        .core_read_pop, .rx_word, .rx_word_valid, .fifo_empty, .lock, .buffer_active(),
        .term_active(), .delay_adjust_on, .delay_step_up, .delay_counter_clear, .tx_side_reset,
        .tx_oe, .tx_word, .lp_out(2'h0), .lp_in(), .fwd_bit_tick(), .fwd_word_tick());
    hsb_remote u_hsb_remote (.sys_clk, .pad_out(pad_in), .rx_bit_clock, .rx_word_clock, .tx_bit_clock,
        .tx_word_clock, .rem_pad);
    ////////////////////////////////////////////////////////////////////////////////
    task automatic chk(input logic [31:0] s, input logic [31:0] e);
        n_checks++;
        if (s !== e) begin
            n_fail++;
            $display("wrong value at %0t: got %h exp %h", $time, s, e);
        end
    endtask : chk
    task automatic end_sim();
        $display("checks %0d fails %0d", n_checks, n_fail);
        if (n_fail == 0 && n_checks > 0)
            $display("*** PASS ***");
        else
            $display("*** FAIL ***");
        $finish;
    endtask : end_sim
    task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d, m);
        psel <= 1;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        if (!w) begin
            rd_e.push_back(d);
            rd_m.push_back(m);
        end
        @(posedge sys_clk);
        penable <= 1;
        do @(posedge sys_clk); while (pready !== 1'h1);
        psel <= 0;
        penable <= 0;
        @(posedge sys_clk);
    endtask : apb
    task automatic rx(input logic [9:0] w, input int n);
        rx_q.push_back(32'(w) & ((32'h1 << n) - 1));
        u_hsb_remote.send(w, n);
    endtask : rx
    ////////////////////////////////////////////////////////////////////////////////
    always @(posedge sys_clk) begin
        if (psel && penable && !pwrite && pready && rd_e.size() > 0)
            chk(prdata & rd_m.pop_front(), rd_e.pop_front());
        if (rx_word_valid === 1'h1)
            chk(32'(rx_word), rx_q.size() > 0 ? rx_q.pop_front() : 32'hdead);
    end
    initial begin
        repeat (20000) @(posedge sys_clk);
        n_fail++;
        end_sim();
    end
    initial begin
        void'($urandom(9));
        repeat (5) @(posedge sys_clk);
        resetn <= 1;
        @(posedge sys_clk);
        clk_en <= 0;
        apb(1, 8'h00, 32'h3ff, 0);
        clk_en <= 1;
        apb(0, 8'h00, 32'h8, 32'h1fff);
        apb(0, 8'h04, 32'h802, 32'h3f1f0f1f);
        apb(0, 8'h10, 0, '1);
        apb(1, 8'h00, 32'h20a, 0);
        for (int k = 0; k < 4; k++) begin
            rx_buffer_on <= k[0];
            term_on <= k[1];
            repeat (2) @(posedge sys_clk);
            apb(0, 8'h04, 32'(k) << 2, 32'hc);
        end
        repeat (3) rx(10'($urandom), 10);
        apb(1, 8'h00, 32'h208, 0);
        fork
            rx(10'($urandom), 8);
            begin
                tx_side_reset <= 1;
                repeat (4) @(posedge sys_clk);
                tx_side_reset <= 0;
            end
        join
        delay_adjust_on <= 1;
        delay_step_up <= 1;
        repeat (3) rx(10'($urandom), 8);
        delay_step_up <= 0;
        rx(10'h055, 8);
        apb(0, 8'h04, 32'h02000000, 32'h3f000000);
        rx_side_reset <= 1;
        repeat (2) @(posedge sys_clk);
        rx_side_reset <= 0;
        apb(0, 8'h04, 32'h2, 32'h3f000002);
        delay_step_up <= 1;
        rx(10'h0aa, 8);
        delay_adjust_on <= 0;
        delay_counter_clear <= 1;
        rx(10'h033, 8);
        delay_counter_clear <= 0;
        apb(0, 8'h04, 0, 32'h3f000000);
        apb(1, 8'h00, 32'h228, 0);
        repeat (2) rx(10'($urandom), 8);
        apb(0, 8'h04, 32'h00020000, 32'h001f0002);
        repeat (3) begin
            core_read_pop <= 1;
            @(posedge sys_clk);
            core_read_pop <= 0;
            repeat (3) @(posedge sys_clk);
        end
        apb(0, 8'h04, 32'h2, 32'h001f0002);
        apb(1, 8'h00, 32'h248, 0);
        delay_adjust_on <= 1;
        delay_step_up <= 0;
        repeat (18) rx(10'h0a5, 8);
        chk(32'(lock), 1);
        delay_counter_clear <= 1;
        rx(10'h0a5, 8);
        chk(32'(lock), 0);
        delay_counter_clear <= 0;
        apb(0, 8'h08, 32'h0a5, 32'h3ff);
        rx_side_reset <= 1;
        @(posedge sys_clk);
        rx_side_reset <= 0;
        apb(1, 8'h00, 32'h1d80, 0);
        apb(0, 8'h04, 32'h808, 32'hf08);
        apb(0, 8'h0c, 32'h8, 32'hf070f);
        rx(10'($urandom), 8);
        tx_oe <= 1;
        repeat (2) begin
            tx_word <= 10'($urandom);
            @(posedge sys_clk);
            u_hsb_remote.recv(got, 8);
            chk(32'(got), 32'(tx_word) & 32'hff);
        end
        chk(32'(pad_oe_n), 0);
        tx_oe <= 0;
        repeat (2) @(posedge sys_clk);
        chk(32'(pad_oe_n), 1);
        end_sim();
    end
endmodule : hsb_top_bench
`default_nettype wire
